// File: common/sst_regs.vh
// register map, field positions, reset values and timing constants
// for the sensor status and threshold register bank; definitions only
`ifndef SST_REGS_VH
`define SST_REGS_VH

`define SST_ADDR_W        5
`define SST_ADDR_THR_XP   5'h10
`define SST_ADDR_THR_YP   5'h11
`define SST_ADDR_THR_XN   5'h12
`define SST_ADDR_THR_YN   5'h13
`define SST_ADDR_STATUS   5'h14
`define SST_ADDR_COUNT    5'h15
`define SST_ADDR_OFFC_X   5'h16
`define SST_ADDR_OFFC_Y   5'h17
`define SST_ADDR_RSV_A    5'h1c
`define SST_ADDR_RSV_B    5'h1d

`define SST_RST_BYTE      8'h00
`define SST_ZERO_BYTE     8'h00

// fault_status bit positions
`define SST_ST_RESET_OCCURRED_FLAG     0
`define SST_ST_OFFX       1
`define SST_ST_OFFY       2
`define SST_ST_MISO       3
`define SST_ST_INIT       4
`define SST_ST_IDE        6

`define SST_CRC_SEED      3'h7
`define SST_PRESCALE_W    10
`define SST_PRESCALE_ONE  10'h001
`define SST_COUNT_ONE     8'h01
`define SST_INIT_CYCLES   16'h0040
`define SST_INIT_ONE      16'h0001

`endif

// File: src/sst_regs.v
// sensor status and threshold register bank: arming thresholds,
// fault status with read-to-clear flags, oscillator tick counter,
// offset correction readback and 3-bit crc checks.
// assumes a serial-port slave in the clk domain drives regAddr,
// regWrEn and regRdEn as one-cycle strobes; rst_b is the supply
// monitor reset; oscRef is the primary oscillator from another domain.
`include "sst_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module sst_regs #(
  parameter OTP_W   = 64,
  parameter INIT_W  = 16
) (
  input  wire              clk,
  input  wire              rst_b,
  input  wire [4:0]        regAddr,
  input  wire [7:0]        regWrData,
  input  wire              regWrEn,
  input  wire              regRdEn,
  output reg  [7:0]        regRdData,
  input  wire              initLock,
  input  wire [2:0]        userCrcRef,
  input  wire [OTP_W-1:0]  otpData,
  input  wire [2:0]        otpCrcRef,
  input  wire              otherFault,
  input  wire              misoMismatch,
  input  wire              offLimitX,
  input  wire              offLimitY,
  input  wire [7:0]        offCorrX,
  input  wire [7:0]        offCorrY,
  input  wire              oscRef,
  output reg  [7:0]        thrXPos,
  output reg  [7:0]        thrYPos,
  output reg  [7:0]        thrXNeg,
  output reg  [7:0]        thrYNeg,
  output reg               armXPosEn,
  output reg               armXNegEn,
  output reg               armYPosEn,
  output reg               armYNegEn,
  output reg               armXAxisEn,
  output reg               armYAxisEn,
  output reg               initInProgress,
  output reg               dataError
);

  // serial crc, msb first, x^3+x+1
  function [2:0] crc3;
    input [OTP_W-1:0] data;
    input integer     nbits;
    integer           i;
    reg     [2:0]     c;
    reg               fb;
    begin
      c = `SST_CRC_SEED;
      for (i = nbits - 1; i >= 0; i = i - 1)
      begin
        fb = c[2] ^ data[i];
        c  = {c[1], c[0] ^ fb, fb};
      end
      crc3 = c;
    end
  endfunction

  reg  [7:0]            thrXP_q, thrYP_q, thrXN_q, thrYN_q;
  reg  [7:0]            offX_q, offY_q;
  reg  [7:0]            count_q;
  reg  [`SST_PRESCALE_W-1:0] pre_q;
  reg  [INIT_W-1:0]     initCnt_q;
  reg                   init_q, reset_occurred_flag_q, ide_q, miso_q;
  reg                   offXf_q, offYf_q, wrCrcFault_q;
  reg                   oscS1_q, oscS2_q, oscS3_q;
  reg  [7:0]            rd_d;

  wire stRead = regRdEn && (regAddr == `SST_ADDR_STATUS);
  wire wrOk   = regWrEn && !initLock;
  wire [OTP_W-1:0] userWord =
    {{(OTP_W-32){1'b0}}, thrXP_q, thrYP_q, thrXN_q, thrYN_q};
  wire userBad = initLock && (crc3(userWord, 32) != userCrcRef);
  wire otpBad  = (crc3(otpData, OTP_W) != otpCrcRef);
  wire oscRise = oscS2_q && !oscS3_q;

  // rst_b is the supply monitor's combined good signal
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      thrXP_q      <= `SST_RST_BYTE;
      thrYP_q      <= `SST_RST_BYTE;
      thrXN_q      <= `SST_RST_BYTE;
      thrYN_q      <= `SST_RST_BYTE;
      offX_q       <= `SST_RST_BYTE;
      offY_q       <= `SST_RST_BYTE;
      count_q      <= `SST_RST_BYTE;
      pre_q        <= {`SST_PRESCALE_W{1'b0}};
      initCnt_q    <= {INIT_W{1'b0}};
      init_q       <= 1'b1;
      reset_occurred_flag_q     <= 1'b1;
      ide_q        <= 1'b0;
      miso_q       <= 1'b0;
      offXf_q      <= 1'b0;
      offYf_q      <= 1'b0;
      wrCrcFault_q <= 1'b0;
      oscS1_q      <= 1'b0;
      oscS2_q      <= 1'b0;
      oscS3_q      <= 1'b0;
    end
    else
    begin
      // writes only while init open; plain bytes
      if (wrOk && regAddr == `SST_ADDR_THR_XP)
        thrXP_q <= regWrData;
      if (wrOk && regAddr == `SST_ADDR_THR_YP)
        thrYP_q <= regWrData;
      if (wrOk && regAddr == `SST_ADDR_THR_XN)
        thrXN_q <= regWrData;
      if (wrOk && regAddr == `SST_ADDR_THR_YN)
        thrYN_q <= regWrData;
      offX_q <= offCorrX;
      offY_q <= offCorrY;
      oscS1_q <= oscRef;
      oscS2_q <= oscS1_q;
      oscS3_q <= oscS2_q;
      if (oscRise)
      begin
        pre_q <= pre_q + `SST_PRESCALE_ONE;
        if (&pre_q)
          count_q <= count_q + `SST_COUNT_ONE;
      end
      // init flag clears by itself, reads ignored
      if (init_q)
      begin
        initCnt_q <= initCnt_q + `SST_INIT_ONE;
        if (initCnt_q == `SST_INIT_CYCLES - `SST_INIT_ONE)
          init_q <= 1'b0;
      end
      // writable crc fault sticks until reset
      if (userBad)
        wrCrcFault_q <= 1'b1;
      // set terms win over the read clear
      // data error from any crc or internal fault
      ide_q   <= userBad || wrCrcFault_q || otpBad || otherFault
                 || (ide_q && !stRead);
      miso_q  <= misoMismatch || (miso_q && !stRead);
      offXf_q <= offLimitX || (offXf_q && !stRead);
      offYf_q <= offLimitY || (offYf_q && !stRead);
      reset_occurred_flag_q <= init_q || (reset_occurred_flag_q && !stRead);
    end
  end

  always @*
  begin
    rd_d = `SST_ZERO_BYTE;
    case (regAddr)
      `SST_ADDR_THR_XP: rd_d = thrXP_q;
      `SST_ADDR_THR_YP: rd_d = thrYP_q;
      `SST_ADDR_THR_XN: rd_d = thrXN_q;
      `SST_ADDR_THR_YN: rd_d = thrYN_q;
      // status composed; unused bits read zero
      `SST_ADDR_STATUS:
      begin
        rd_d[`SST_ST_RESET_OCCURRED_FLAG] = reset_occurred_flag_q;
        rd_d[`SST_ST_OFFX]   = offXf_q;
        rd_d[`SST_ST_OFFY]   = offYf_q;
        rd_d[`SST_ST_MISO]   = miso_q;
        rd_d[`SST_ST_INIT]   = init_q;
        rd_d[`SST_ST_IDE]    = ide_q;
      end
      `SST_ADDR_COUNT:  rd_d = count_q;
      `SST_ADDR_OFFC_X: rd_d = offX_q;
      `SST_ADDR_OFFC_Y: rd_d = offY_q;
      // reserved slots: writes dropped, read zero
      default:          rd_d = `SST_ZERO_BYTE;
    endcase
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      regRdData      <= `SST_ZERO_BYTE;
      thrXPos        <= `SST_RST_BYTE;
      thrYPos        <= `SST_RST_BYTE;
      thrXNeg        <= `SST_RST_BYTE;
      thrYNeg        <= `SST_RST_BYTE;
      armXPosEn      <= 1'b0;
      armXNegEn      <= 1'b0;
      armYPosEn      <= 1'b0;
      armYNegEn      <= 1'b0;
      armXAxisEn     <= 1'b0;
      armYAxisEn     <= 1'b0;
      initInProgress <= 1'b1;
      dataError      <= 1'b0;
    end
    else
    begin
      if (regRdEn)
        regRdData <= rd_d;
      thrXPos   <= thrXP_q;
      thrYPos   <= thrYP_q;
      thrXNeg   <= thrXN_q;
      thrYNeg   <= thrYN_q;
      armXPosEn <= |thrXP_q;
      armXNegEn <= |thrXN_q;
      armYPosEn <= |thrYP_q;
      armYNegEn <= |thrYN_q;
      // both zero kills axis and its pin, mode ignored
      armXAxisEn <= (|thrXP_q) || (|thrXN_q);
      armYAxisEn <= (|thrYP_q) || (|thrYN_q);
      initInProgress <= init_q;
      dataError      <= ide_q;
    end
  end

endmodule // sst_regs

`default_nettype wire

// File: tb/sst_osc_model.sv
// primary oscillator source for the register bank
// assumes the bench samples it with its own clock
`timescale 1ns/1ps
`default_nettype none
module sst_osc_model (
  output var logic oscRef
);
  // runs free; the odd start offset keeps it off the bench clock phase
  initial
  begin
    oscRef = 1'b0;
    #3;
    forever #80 oscRef = ~oscRef;
  end
endmodule // sst_osc_model
`default_nettype wire

// File: tb/sst_regs_checker.sv
// port assertions for the register bank
// bound to sst_regs; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module sst_regs_checker (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [4:0] regAddr,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic       initLock,
  input wire logic [7:0] thrXPos,
  input wire logic [7:0] thrXNeg,
  input wire logic       armXPosEn,
  input wire logic       armXAxisEn,
  input wire logic       initInProgress,
  input wire logic       dataError
);
  wire stRd = regRdEn && regAddr == 5'h14;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_thr_locked:
  assert property (initLock && $past(initLock) && regWrEn &&
    regAddr == 5'h10 |=> $stable(thrXPos)) else $error("locked write");
  a_arm_pol:
  assert property ($stable(thrXPos) ##1 $stable(thrXPos) |->
    armXPosEn == (thrXPos != 8'h00)) else $error("pos enable");
  a_arm_axis:
  assert property ($stable({thrXPos, thrXNeg}) ##1
    $stable({thrXPos, thrXNeg}) |-> armXAxisEn == (|{thrXPos, thrXNeg}))
    else $error("axis enable");
  a_rd_hold:
  assert property (!regRdEn && !$past(regRdEn) |=> $stable(regRdData))
    else $error("read data moved");
  a_unused_zero:
  assert property (stRd |-> ##1 !regRdData[7] && !regRdData[5])
    else $error("unused bits set");
  a_rsvd_zero:
  assert property (regRdEn && regAddr == 5'h1c |-> ##1
    regRdData == 8'h00) else $error("reserved read");
  a_de_fell:
  assert property ($fell(dataError) |-> $past(stRd) || $past(stRd, 2))
    else $error("error flag dropped");
  a_init_stays:
  assert property (!initInProgress |=> !initInProgress)
    else $error("init flag back");
endmodule // sst_regs_checker
bind sst_regs sst_regs_checker sst_regs_checker_inst (.*);
`default_nettype wire

// File: tb/sst_regs_tb_top.sv
// self-checking bench for sst_regs against a threshold/status model
// assumes the checker and oscillator model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module sst_regs_tb_top;
  logic clk = 0, rst_b = 0, regWrEn = 0, regRdEn = 0, initLock = 0;
  logic otherFault = 0, misoMismatch = 0, offLimitX = 0, offLimitY = 0;
  logic oscRef, initInProgress, dataError, armXPosEn, armXNegEn;
  logic armYPosEn, armYNegEn, armXAxisEn, armYAxisEn;
  logic [4:0] regAddr = '0;
  logic [7:0] regWrData = '0, offCorrX = '0, offCorrY = '0, regRdData;
  logic [7:0] thrXPos, thrYPos, thrXNeg, thrYNeg;
  logic [2:0] userCrcRef = '0, otpCrcRef = '0;
  logic [63:0] otpData = '0;
  int bad_count = 0, num_checks = 0, c0, k, last, thr[4];
  sst_regs sst_regs_inst (.*);
  sst_osc_model sst_osc_model_inst (.oscRef(oscRef));
  always #10 clk = ~clk;
  function automatic logic [2:0] crc3(logic [63:0] d, int n);
    logic [2:0] c = 3'h7;
    for (int i = n - 1; i >= 0; i--)
      c = {c[1], c[0] ^ c[2] ^ d[i], c[2] ^ d[i]};
    return c;
  endfunction
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(int a, int d);
    @(negedge clk) {regAddr, regWrData, regWrEn} = {5'(a), 8'(d), 1'b1};
    @(negedge clk) regWrEn = 0;
  endtask
  // negative expectation means capture only, no compare
  task automatic rd(int a, int e);
    @(negedge clk) {regAddr, regRdEn} = {5'(a), 1'b1};
    @(negedge clk) regRdEn = 0;
    @(negedge clk) last = regRdData;
    if (e >= 0) chk($sformatf("reg %h", a), regRdData, 8'(e));
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    c0 = $urandom(44613);
    otpData = {$urandom, $urandom};
    otpCrcRef = crc3(otpData, 64);
    repeat (8) @(negedge clk);
    rst_b = 1;
    rd(5'h14, 8'h11);
    for (k = 0; k < 2; k++)
    begin
      thr = '{k ? 0 : $urandom_range(255, 1), k * $urandom_range(255, 1), 0,
              $urandom_range(255, 1)};
      foreach (thr[i]) wr(16 + i, thr[i]);
      @(negedge clk);
      chk("xpos", armXPosEn, thr[0] != 0);
      chk("yneg", armYNegEn, thr[3] != 0);
      chk("xaxis", armXAxisEn, (thr[0] | thr[2]) != 0);
      foreach (thr[i]) rd(16 + i, thr[i]);
      $display("threshold round %0d done", k);
    end
    {offCorrX, offCorrY} = 16'($urandom);
    wr(5'h1c, 0);
    wr(5'h14, 8'hff);
    rd(5'h16, offCorrX);
    rd(5'h17, offCorrY);
    rd(5'h1c, 0);
    for (c0 = 0; initInProgress !== 1'b0 && c0 < 200; c0++) @(negedge clk);
    if (c0 == 200)
    begin
      bad_count++;
      end_of_test();
    end
    rd(5'h14, 8'h01);
    rd(5'h14, 8'h00);
    @(negedge clk) {offLimitY, offLimitX, misoMismatch, otherFault} = 4'hf;
    @(negedge clk) {offLimitY, offLimitX, misoMismatch, otherFault} = 4'h0;
    rd(5'h14, 8'h4e);
    // event arriving on the read edge must not be lost
    @(negedge clk) {regAddr, regRdEn, offLimitX} = {5'h14, 2'b11};
    @(negedge clk) {regRdEn, offLimitX} = 2'b00;
    rd(5'h14, 8'h02);
    rd(5'h15, -1);
    c0 = last;
    repeat (16381) @(negedge clk);
    rd(5'h15, (c0 + 2) & 255);
    userCrcRef = crc3({8'(thr[0]), 8'(thr[1]), 8'(thr[2]), 8'(thr[3])}, 32);
    initLock = 1;
    wr(5'h10, 8'h5a);
    rd(5'h10, thr[0]);
    chk("dataError", dataError, 0);
    userCrcRef = ~userCrcRef;
    repeat (4) @(negedge clk);
    rd(5'h14, 8'h40);
    rd(5'h14, 8'h40);
    $display("status and lock test done");
    end_of_test();
  end
endmodule // sst_regs_tb_top
`default_nettype wire
